// [logic/stn_distributor_regs.sv]
// Target-byte arrays and non-secure grant fields of the distributor.
//
// Functional notes
// - Target byte selects forwarding CPU interfaces.
// - Affinity routed interrupt: target byte reads zero.
// - Byte and word accesses to target registers.
// - Unimplemented interrupt or interface bits read zero.
// - Registers 0-7 read-only, return reader's bit.
// - Hardwired SPI targets are read-only constants.
// - Secure interrupts hidden from non-secure unless granted.
// - Single element: target registers read zero.
// - Target rewrite anytime; pending never lost.
// - Eight target registers per line-count unit.
// - Registers 0-7 banked; high PE reads zero.
// - Interrupt m at 0x800 plus m, byte lane.
// - Bit b selects CPU interface b.
// - Active interrupts unaffected by target change.
// - Removed interface loses pending; added may take.
// - Writable target bytes reset unknown.
// - Grants secure-only, zero when security disabled.
// - Grant register 0 zero under secure affinity.
// - Grant register 1 always reads zero.
// - Grant register 0 banked per element.
// - Sixteen two-bit fields; non-secure interrupts ignore.
// - Level 00 denies all non-secure access.
// - Level 01 grants set-pending and generation.
// - Level 10 adds clear-pending and active reads.
// - Level 11 adds targets, except register 0.
// - Grant register m/16 at 0xE00, resets zero.
module stn_distributor_regs
    import stn_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_valid,
    input wire logic reg_write,
    input wire logic [11:0] reg_addr,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_secure,
    input wire logic [3:0] reg_pe_index,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic security_disable_bit,
    input wire logic are_secure,
    input wire logic are_nonsecure,
    input wire logic [SPI_COUNT-1:0] spi_secure,
    input wire logic [SPI_COUNT-1:0] spi_pending,
    input wire logic [SPI_COUNT-1:0] spi_active,
    output logic [SPI_COUNT*4-1:0] spi_forward,
    output logic [SPI_COUNT*2-1:0] spi_ns_grant,
    output logic [CPU_IF_COUNT*32-1:0] sgi_ns_grant
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; the low address bits are ignored and lanes come from byte enables.
    wire logic [11:0] tgt_off = reg_addr - TARGET_BASE;
    wire logic [11:0] grant_off = reg_addr - GRANT_BASE;
    wire logic tgt_hit = reg_valid && reg_addr >= TARGET_BASE && reg_addr < TARGET_END;
    wire logic grant_hit = reg_valid && reg_addr >= GRANT_BASE && reg_addr < GRANT_END;
    wire logic [3:0] tgt_idx = tgt_off[5:2];
    wire logic [1:0] grant_idx = grant_off[3:2];
    wire logic is_read = reg_valid && !reg_write;
    wire logic ds = security_disable_bit;
    wire logic pe_ok = reg_pe_index < CPU_IF_COUNT && reg_pe_index < PE_LIMIT;
    wire logic [7:0] own_bit = pe_ok ? (8'h01 << reg_pe_index[2:0]) : 8'h00;

    logic [7:0] tgt_store [SPI_COUNT];
    logic [31:0] grant_bank [CPU_IF_COUNT];
    logic [31:0] grant_spi_reg [GRANT_REG_COUNT-2];
    logic [1:0] grant_spi [SPI_COUNT];
    logic [7:0] tgt_eff [SPI_COUNT];
    logic [3:0] lane_vis;
    logic [31:0] lane_data;
    logic [SPI_COUNT*4-1:0] next_forward;
    logic [SPI_COUNT-1:0] fwd_any;

    ////////////////////////////////////////////////////////////////////////////
    // Per-lane view of the addressed target register.
    for (genvar l = 0; l < 4; l++)
    begin : g_lane
        wire logic is_spi = tgt_idx[3];
        wire logic [4:0] s = {tgt_idx[2:0], 2'(l)};
        wire logic lane_sec = spi_secure[s] && !ds;
        wire logic are_m = lane_sec ? are_secure : are_nonsecure;
        wire logic ns_ok = !lane_sec || grant_spi[s] == GRANT_ROUTE;
        wire logic vis_spi = is_spi && !are_m && (reg_secure || ns_ok);
        wire logic vis_priv = !is_spi && pe_ok;
        assign lane_vis[l] = !SINGLE_PE && (vis_spi || vis_priv);
        assign lane_data[8*l +: 8] = !lane_vis[l] ? 8'h00 : (is_spi ? tgt_eff[s] : own_bit);
    end

    ////////////////////////////////////////////////////////////////////////////
    // SPI target storage; private registers keep no state, so writes there fall away.
    for (genvar s = 0; s < SPI_COUNT; s++)
    begin : g_spi
        wire logic [1:0] lane = 2'(s % 4);
        wire logic is_static = STATIC_SPI_MASK[s];
        wire logic sel = tgt_hit && reg_write && reg_byte_en[lane] && tgt_idx[3]
                         && tgt_idx[2:0] == 3'(s / 4) && lane_vis[lane] && !is_static;
        wire logic are_s = (spi_secure[s] && !ds) ? are_secure : are_nonsecure;
        assign grant_spi[s] = grant_spi_reg[s / 16][2*(s % 16) +: 2];
        assign tgt_eff[s] = SINGLE_PE ? 8'h01 : (is_static ? STATIC_SPI_TARGETS : (tgt_store[s] & CPU_MASK));
        assign spi_ns_grant[2*s +: 2] = (ds || !spi_secure[s]) ? GRANT_NONE : grant_spi[s];
        // Forwarding follows the current targets every cycle: pending stays held upstream,
        // so a retargeted interrupt moves once and is neither lost nor doubled.
        assign next_forward[4*s +: 4] = (spi_pending[s] && !spi_active[s] && !are_s)
                                        ? tgt_eff[s][3:0] : 4'h0;
        assign fwd_any[s] = |spi_forward[4*s +: 4];

        // Targets have no reset value on purpose; software must program them.
        always_ff @(posedge core_clk)
        begin
            if (sel)
            begin
                tgt_store[s] <= reg_wdata[8*(s % 4) +: 8] & CPU_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Banked SOFTWARE_GENERATED_INTERRUPT grants; level 11 means 10 here because SGIs have no target field.
    for (genvar g = 0; g < CPU_IF_COUNT * 16; g++)
    begin : g_sgi
        wire logic [1:0] raw = grant_bank[g / 16][2*(g % 16) +: 2];
        assign sgi_ns_grant[2*g +: 2] = (ds || are_secure) ? GRANT_NONE
                                        : (raw == GRANT_ROUTE ? GRANT_CLEAR : raw);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Grant registers: secure, security-enabled accesses only.
    wire logic grant_ok = grant_hit && reg_secure && !ds;
    wire logic bank_ok = pe_ok && !are_secure;
    wire logic [31:0] grant_rd = !grant_ok ? 32'h0000_0000
                                 : grant_idx == GRANT_IDX_SGI ? (bank_ok ? grant_bank[reg_pe_index[PE_W-1:0]] : 32'h0000_0000)
                                 : grant_idx == GRANT_IDX_PPI ? 32'h0000_0000
                                 : grant_spi_reg[grant_idx[0]];
    wire logic grant_wr = grant_ok && reg_write;

    for (genvar p = 0; p < CPU_IF_COUNT; p++)
    begin : g_bank
        always_ff @(posedge core_clk)
        begin
            if (!nrst)
            begin
                grant_bank[p] <= GRANT_RESET;
            end
            else if (grant_wr && grant_idx == GRANT_IDX_SGI && bank_ok && reg_pe_index[PE_W-1:0] == PE_W'(p))
            begin
                grant_bank[p] <= merge_bytes(grant_bank[p], reg_wdata, reg_byte_en);
            end
        end
    end

    for (genvar r = 0; r < GRANT_REG_COUNT - 2; r++)
    begin : g_grant
        always_ff @(posedge core_clk)
        begin
            if (!nrst)
            begin
                grant_spi_reg[r] <= GRANT_RESET;
            end
            else if (grant_wr && grant_idx == 2'(r + 2))
            begin
                grant_spi_reg[r] <= merge_bytes(grant_spi_reg[r], reg_wdata, reg_byte_en);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer one cycle after the request; unmapped offsets answer zero.
    wire logic [31:0] next_rdata = tgt_hit ? lane_data : grant_rd;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
            spi_forward <= '0;
        end
        else
        begin
            reg_rdata <= is_read ? next_rdata : 32'h0000_0000;
            reg_rvalid <= is_read;
            spi_forward <= next_forward;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (@(posedge core_clk) disable iff (!nrst)
        is_read |=> reg_rvalid)
        else $error("read not answered next cycle");

    chk_own_bit_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !tgt_idx[3] && pe_ok && !SINGLE_PE) |=> reg_rdata == {4{$past(own_bit)}})
        else $error("private target read not own bit");

    chk_high_pe_raz: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !tgt_idx[3] && reg_pe_index > 4'h7) |=> reg_rdata == 32'h0000_0000)
        else $error("high element read not zero");

    chk_cpu_mask: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read) |=> (reg_rdata & ~{4{CPU_MASK}}) == 32'h0000_0000)
        else $error("unimplemented interface bit read set");

    chk_ns_hidden: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !lane_vis[0]) |=> reg_rdata[7:0] == 8'h00)
        else $error("hidden target byte visible");

    chk_grant_ds_raz: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && is_read && ds) |=> reg_rdata == 32'h0000_0000)
        else $error("grant readable with security disabled");

    chk_grant_ns_raz: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && is_read && !reg_secure) |=> reg_rdata == 32'h0000_0000)
        else $error("grant readable by non-secure access");

    chk_ppi_grant_raz: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && is_read && grant_idx == GRANT_IDX_PPI) |=> reg_rdata == 32'h0000_0000)
        else $error("grant register 1 not zero");

    chk_active_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (spi_active != '0) |=> (fwd_any & $past(spi_active)) == '0)
        else $error("active interrupt forwarded");

    chk_spi_grant_ds: assert property (@(posedge core_clk) disable iff (!nrst)
        ds |-> spi_ns_grant == '0)
        else $error("grant level with security disabled");

    ////////////////////////////////////////////////////////////////////////////
    // Read port shape and reset state.
    chk_write_silent: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_valid && reg_write) |=> !reg_rvalid)
        else $error("write answered with read valid");

    chk_idle_rdata_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        !reg_rvalid |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero while idle");

    chk_rvalid_cause: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_rvalid |-> $past(is_read))
        else $error("read valid without a read");

    chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        (is_read && !tgt_hit && !grant_hit) |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped offset read not zero");

    chk_reset_outputs: assert property (@(posedge core_clk)
        !nrst |=> !reg_rvalid && reg_rdata == 32'h0000_0000 && spi_forward == '0)
        else $error("outputs not cleared by reset");

    chk_grant_reset: assert property (@(posedge core_clk)
        !nrst |=> grant_spi_reg[0] == GRANT_RESET && grant_spi_reg[1] == GRANT_RESET && grant_bank[0] == GRANT_RESET)
        else $error("grant registers not cleared by reset");

    ////////////////////////////////////////////////////////////////////////////
    // Target byte storage and visibility.
    chk_single_pe_raz: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && SINGLE_PE) |=> reg_rdata == 32'h0000_0000)
        else $error("single element target read not zero");

    chk_static_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && reg_write && tgt_idx == 4'hF) |=> tgt_eff[SPI_COUNT-1] == STATIC_SPI_TARGETS)
        else $error("hardwired target byte changed");

    chk_byte_lane_keep: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && reg_write && reg_secure && tgt_idx == 4'h8 && !reg_byte_en[0]) |=> $stable(tgt_store[0]))
        else $error("disabled byte lane written");

    chk_byte_lane_lands: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && reg_write && reg_secure && !are_secure && !are_nonsecure && tgt_idx == 4'h8
         && reg_byte_en[1] && !SINGLE_PE) |=> tgt_store[1] == ($past(reg_wdata[15:8]) & CPU_MASK))
        else $error("enabled byte lane not written");

    chk_target_ns_wi: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && reg_write && !reg_secure && !ds && spi_secure[0] && grant_spi[0] != GRANT_ROUTE
         && tgt_idx == 4'h8) |=> $stable(tgt_store[0]))
        else $error("hidden target byte written");

    chk_affinity_wi: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && reg_write && tgt_idx == 4'h8 && are_secure && are_nonsecure)
        |=> $stable(tgt_store[0]) && $stable(tgt_store[1]) && $stable(tgt_store[2]) && $stable(tgt_store[3]))
        else $error("affinity routed target byte written");

    chk_ns_denied_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !reg_secure && !ds && tgt_idx == 4'h8 && spi_secure[0]
         && grant_spi[0] == GRANT_NONE) |=> reg_rdata[7:0] == 8'h00)
        else $error("denied target byte visible");

    chk_set_level_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !reg_secure && !ds && tgt_idx == 4'h8 && spi_secure[0]
         && grant_spi[0] == GRANT_SET) |=> reg_rdata[7:0] == 8'h00)
        else $error("set level exposes target byte");

    chk_clear_level_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !reg_secure && !ds && tgt_idx == 4'h8 && spi_secure[0]
         && grant_spi[0] == GRANT_CLEAR) |=> reg_rdata[7:0] == 8'h00)
        else $error("clear level exposes target byte");

    chk_ns_granted_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (tgt_hit && is_read && !reg_secure && !ds && !are_secure && !SINGLE_PE && tgt_idx == 4'h8
         && spi_secure[0] && grant_spi[0] == GRANT_ROUTE) |=> reg_rdata[7:0] == $past(tgt_eff[0]))
        else $error("granted target byte hidden");

    ////////////////////////////////////////////////////////////////////////////
    // Forwarding towards the CPU interfaces.
    chk_fwd_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        (spi_pending == '0) |=> spi_forward == '0)
        else $error("forward without pending");

    chk_fwd_affinity: assert property (@(posedge core_clk) disable iff (!nrst)
        (are_secure && are_nonsecure) |=> spi_forward == '0)
        else $error("affinity routed interrupt forwarded");

    chk_fwd_active: assert property (@(posedge core_clk) disable iff (!nrst)
        spi_active[1] |=> spi_forward[7:4] == 4'h0)
        else $error("active interrupt retargeted");

    chk_fwd_follows: assert property (@(posedge core_clk) disable iff (!nrst)
        (spi_pending[1] && !spi_active[1] && !are_nonsecure && !spi_secure[1])
        |=> spi_forward[7:4] == $past(tgt_eff[1][3:0]))
        else $error("forward not following targets");

    ////////////////////////////////////////////////////////////////////////////
    // Grant registers and grant levels.
    chk_sgi_grant_ds: assert property (@(posedge core_clk) disable iff (!nrst)
        ds |-> sgi_ns_grant == '0)
        else $error("software interrupt grant with security disabled");

    chk_sgi_grant_are: assert property (@(posedge core_clk) disable iff (!nrst)
        are_secure |-> sgi_ns_grant == '0)
        else $error("software interrupt grant under secure affinity");

    chk_sgi_no_route: assert property (@(posedge core_clk) disable iff (!nrst)
        sgi_ns_grant[1:0] != GRANT_ROUTE)
        else $error("software interrupt grant shows target level");

    chk_nonsec_grant: assert property (@(posedge core_clk) disable iff (!nrst)
        !spi_secure[1] |-> spi_ns_grant[3:2] == GRANT_NONE)
        else $error("grant level on non-secure interrupt");

    chk_grant_ns_wi: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && !reg_secure)
        |=> $stable(grant_spi_reg[0]) && $stable(grant_spi_reg[1]) && $stable(grant_bank[0]))
        else $error("non-secure grant write landed");

    chk_grant_ds_wi: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && ds)
        |=> $stable(grant_spi_reg[0]) && $stable(grant_spi_reg[1]) && $stable(grant_bank[0]))
        else $error("grant write landed with security disabled");

    chk_ppi_grant_wi: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && grant_idx == GRANT_IDX_PPI)
        |=> $stable(grant_spi_reg[0]) && $stable(grant_spi_reg[1]) && $stable(grant_bank[0]))
        else $error("grant register 1 write landed");

    chk_bank_high_pe: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && reg_pe_index >= 4'h4)
        |=> $stable(grant_bank[0]) && $stable(grant_bank[1]) && $stable(grant_bank[2]) && $stable(grant_bank[3]))
        else $error("bank written by unconnected element");

    chk_grant_secure_rw: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && reg_secure && !ds && grant_idx == 2'h2 && reg_byte_en == 4'hF)
        |=> grant_spi_reg[0] == $past(reg_wdata))
        else $error("secure grant write lost");

    chk_bank_write: assert property (@(posedge core_clk) disable iff (!nrst)
        (grant_hit && reg_write && reg_secure && !ds && !are_secure && grant_idx == GRANT_IDX_SGI
         && reg_pe_index == 4'h1 && reg_byte_en == 4'hF) |=> grant_bank[1] == $past(reg_wdata))
        else $error("banked grant write lost");

endmodule

// [logic/stn_pkg.sv]
// Constants for the target-byte and non-secure grant register logic.
package stn_pkg;
    localparam int CPU_IF_COUNT = 4;
    localparam int PE_W = 2;
    localparam logic [7:0] CPU_MASK = 8'h0F;
    localparam logic [3:0] PE_LIMIT = 4'h8;
    localparam int LINE_COUNT_VALUE = 1;
    localparam int NUM_INT = 32 * (LINE_COUNT_VALUE + 1);
    localparam int SPI_COUNT = NUM_INT - 32;
    localparam int TARGET_REG_COUNT = 8 * (LINE_COUNT_VALUE + 1);
    localparam int GRANT_REG_COUNT = NUM_INT / 16;
    localparam logic [11:0] TARGET_BASE = 12'h800;
    localparam logic [11:0] TARGET_END = 12'h840;
    localparam logic [11:0] GRANT_BASE = 12'hE00;
    localparam logic [11:0] GRANT_END = 12'hE10;
    localparam logic [1:0] GRANT_IDX_SGI = 2'h0;
    localparam logic [1:0] GRANT_IDX_PPI = 2'h1;
    localparam logic [31:0] GRANT_RESET = 32'h0000_0000;
    localparam logic [31:0] STATIC_SPI_MASK = 32'h8000_0000;
    localparam logic [7:0] STATIC_SPI_TARGETS = 8'h01;
    localparam logic [1:0] GRANT_NONE = 2'h0;
    localparam logic [1:0] GRANT_SET = 2'h1;
    localparam logic [1:0] GRANT_CLEAR = 2'h2;
    localparam logic [1:0] GRANT_ROUTE = 2'h3;
    localparam logic SINGLE_PE = (CPU_IF_COUNT == 1);
endpackage

// [testbench/stn_cpu_if_model.sv]
// Model of the CPU interfaces that take forwarded shared interrupts.
module stn_cpu_if_model
    import stn_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [SPI_COUNT*4-1:0] spi_forward,
    input wire logic take_en,
    input wire logic clear_en,
    output logic [SPI_COUNT-1:0] spi_active,
    output logic [CPU_IF_COUNT-1:0] if_irq
);
    logic [SPI_COUNT-1:0] offered;
    always_comb
    begin
        offered = '0;
        if_irq = '0;
        for (int j = 0; j < SPI_COUNT; j++)
        begin
            offered[j] = |spi_forward[4*j +: 4];
            if_irq = if_irq | spi_forward[4*j +: 4];
        end
    end
    ////////////////////////////////////////
    // Every offered interrupt is taken at once, which is cruder than real arbitration.
    always_ff @(posedge core_clk)
    begin
        if (!nrst || clear_en)
            spi_active <= '0;
        else if (take_en)
            spi_active <= spi_active | offered;
    end
endmodule

// [testbench/test_spi_target_and_ns_access.sv]
// Self-checking bench for the target-byte and grant register logic.
module test_spi_target_and_ns_access
    import stn_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic wr; logic [11:0] a; logic [3:0] be; logic [31:0] wd; logic s; logic [3:0] pe;
        logic [31:0] ex;} stn_row_type;
    localparam stn_row_type ROWS [22] = '{
        '{1'b1, 12'h820, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'h820, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0F0F0F0F},
        '{1'b1, 12'h820, 4'h2, 32'h00000300, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'h820, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0F0F030F},
        '{1'b0, 12'h800, 4'h0, 32'h0, 1'b1, 4'h2, 32'h04040404}, '{1'b0, 12'h800, 4'h0, 32'h0, 1'b1, 4'h9, 32'h0},
        '{1'b1, 12'h800, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'h800, 4'h0, 32'h0, 1'b1, 4'h0, 32'h01010101},
        '{1'b1, 12'h83C, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'h83C, 4'h0, 32'h0, 1'b1, 4'h0, 32'h010F0F0F},
        '{1'b1, 12'hE08, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'hE08, 4'h0, 32'h0, 1'b1, 4'h0, 32'hFFFFFFFF},
        '{1'b0, 12'hE08, 4'h0, 32'h0, 1'b0, 4'h0, 32'h0}, '{1'b1, 12'hE04, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0},
        '{1'b0, 12'hE04, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'h900, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0},
        '{1'b0, 12'h820, 4'h0, 32'h0, 1'b0, 4'h0, 32'h0F0F030F}, '{1'b1, 12'hE08, 4'hF, 32'h0, 1'b1, 4'h0, 32'h0},
        '{1'b0, 12'h820, 4'h0, 32'h0, 1'b0, 4'h0, 32'h0F0F0300}, '{1'b1, 12'hE00, 4'hF, 32'hAAAAAAAA, 1'b1, 4'h1, 32'h0},
        '{1'b0, 12'hE00, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0}, '{1'b0, 12'hE00, 4'h0, 32'h0, 1'b1, 4'h1, 32'hAAAAAAAA}};
    logic core_clk, nrst, reg_valid, reg_write, reg_secure, reg_rvalid, take_en, clear_en;
    logic security_disable_bit, are_secure, are_nonsecure;
    logic [11:0] reg_addr;
    logic [3:0] reg_byte_en, reg_pe_index;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [SPI_COUNT-1:0] spi_secure, spi_pending, spi_active;
    logic [SPI_COUNT*4-1:0] spi_forward;
    logic [SPI_COUNT*2-1:0] spi_ns_grant;
    logic [CPU_IF_COUNT*32-1:0] sgi_ns_grant;
    logic [CPU_IF_COUNT-1:0] if_irq;
    int n_mismatch, checked;
    stn_distributor_regs stn_distributor_regs_i (.core_clk, .nrst, .reg_valid, .reg_write, .reg_addr, .reg_byte_en,
        .reg_wdata, .reg_secure, .reg_pe_index, .reg_rdata, .reg_rvalid, .security_disable_bit, .are_secure,
        .are_nonsecure, .spi_secure, .spi_pending, .spi_active, .spi_forward, .spi_ns_grant, .sgi_ns_grant);
    stn_cpu_if_model stn_cpu_if_model_i (.core_clk, .nrst, .spi_forward, .take_en, .clear_en, .spi_active, .if_irq);
    ////////////////////////////////////////
    task automatic report_and_stop;
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [159:0] seen, input logic [159:0] ex);
        checked++;
        if (seen !== ex)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, ex);
        end
    endtask
    // An idle cycle before each request keeps the strobe from being driven twice in one step.
    task automatic acc(input stn_row_type r);
        int i;
        @(posedge core_clk);
        #1;
        {reg_valid, reg_write, reg_addr, reg_byte_en, reg_wdata, reg_secure, reg_pe_index} = {1'b1, r.wr, r.a,
            r.be, r.wd, r.s, r.pe};
        @(posedge core_clk);
        #1;
        reg_valid = 1'b0;
        for (i = 0; !r.wr && reg_rvalid !== 1'b1 && i < 4; i++)
            @(posedge core_clk);
        if (i == 4)
        begin
            n_mismatch++;
            report_and_stop();
        end
        rd = reg_rdata;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end
    ////////////////////////////////////////
    initial
    begin
        {nrst, reg_valid, reg_write, reg_addr, reg_byte_en, reg_wdata, reg_secure, reg_pe_index} = '0;
        {security_disable_bit, are_secure, are_nonsecure, spi_pending, take_en, clear_en} = '0;
        spi_secure = 32'h00000001;
        repeat (10) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        chk({reg_rvalid, spi_forward}, 129'h0);
        foreach (ROWS[i])
        begin
            acc(ROWS[i]);
            if (!ROWS[i].wr)
                chk(rd, ROWS[i].ex);
        end
        chk(sgi_ns_grant[63:32], 32'hAAAAAAAA);
        acc('{1'b1, 12'hE08, 4'hF, 32'hFFFFFFFF, 1'b1, 4'h0, 32'h0});
        chk(spi_ns_grant[3:0], 4'h3);
        spi_pending = 32'h00000002;
        repeat (2) @(posedge core_clk);
        #1;
        chk({spi_forward[7:4], if_irq}, 8'h33);
        take_en = 1'b1;
        @(posedge core_clk);
        #1;
        take_en = 1'b0;
        acc('{1'b1, 12'h820, 4'h2, 32'h00000400, 1'b1, 4'h0, 32'h0});
        repeat (2) @(posedge core_clk);
        #1;
        chk(spi_forward[7:4], 4'h0);
        clear_en = 1'b1;
        @(posedge core_clk);
        #1;
        clear_en = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({spi_forward[7:4], if_irq}, 8'h44);
        are_nonsecure = 1'b1;
        acc('{1'b0, 12'h820, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0});
        chk({spi_forward[7:4], rd}, 36'h00000000F);
        security_disable_bit = 1'b1;
        acc('{1'b0, 12'hE08, 4'h0, 32'h0, 1'b1, 4'h0, 32'h0});
        chk({spi_ns_grant, rd}, 96'h0);
        nrst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({reg_rvalid, spi_forward}, 129'h0);
        report_and_stop();
    end
endmodule
